// ===== rtl/motor_current_scaling_ramp.sv
/*
 motor current scaling with run/hold selection and power-down / power-up
 ramps, plus the apb register file that steers it.
 assumes step_pulse and the sine inputs are synchronous to clk and that the
 sine values are signed coil targets updated by the sequencer outside.
*/
`timescale 1ns/10ps
`default_nettype none

module motor_current_scaling_ramp #(
    parameter int                         SINE_W          = 9,
    parameter logic [20:0]                STANDSTILL_CNT  = 21'(motor_current_pkg::STANDSTILL_CLKS),
    parameter logic [motor_current_pkg::CNT_W-1:0] WAIT_UNIT =
        motor_current_pkg::CNT_W'(motor_current_pkg::WAIT_UNIT_CLKS),
    parameter logic [motor_current_pkg::CNT_W-1:0] HOLD_UNIT =
        motor_current_pkg::CNT_W'(motor_current_pkg::HOLD_UNIT_CLKS)
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire motor_current_pkg::apb_req_t apb_req,
    output motor_current_pkg::apb_rsp_t     apb_rsp,
    input  wire logic                       step_pulse,
    input  wire logic                       adapt_en,
    input  wire logic [4:0]                 adapt_scale,
    input  wire logic signed [SINE_W-1:0]   sine_a,
    input  wire logic signed [SINE_W-1:0]   sine_b,
    output logic signed [SINE_W-1:0]        coil_target_a,
    output logic signed [SINE_W-1:0]        coil_target_b,
    output logic [4:0]                      applied_scale,
    output logic [1:0]                      full_scale_current,
    output logic                            standstill_flag
);
    import motor_current_pkg::*;

    localparam logic [CNT_W-1:0] RUN_UNIT = CNT_W'(RUN_UNIT_CLKS);
    localparam logic [CNT_W-1:0] ONE = 28'h0000001;

    logic [4:0]       hold_current_scale;
    logic [4:0]       run_current_scale;
    logic [3:0]       hold_ramp_interval;
    logic [3:0]       run_ramp_interval;
    logic [7:0]       standstill_wait_time;
    logic [20:0]      idle_cnt;
    logic [CNT_W-1:0] timer;
    logic [4:0]       cur_scale;
    logic [4:0]       run_target;
    ramp_state_t      state;
    ramp_state_t      next_state;
    logic [4:0]       next_scale;
    logic [CNT_W-1:0] next_timer;
    logic             wr_en;
    logic             setup;
    logic             mapped;
    logic [31:0]      rd_word;

    // scale a signed coil value by (s+1)/32, arithmetic shift keeps the sign
    function automatic logic signed [SINE_W-1:0] scale_coil(
        input logic signed [SINE_W-1:0] v,
        input logic [4:0]               s
    );
        logic signed [SINE_W+6:0] prod;
        prod = v * $signed({1'b0, 6'({1'b0, s}) + 6'h01});
        return SINE_W'(prod >>> 5);
    endfunction : scale_coil

    // merge write data into a register word under the byte strobes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // clocks per ramp step; zero means the step is taken at once
    function automatic logic [CNT_W-1:0] step_clks(
        input logic [3:0]       n,
        input logic [CNT_W-1:0] unit
    );
        logic [CNT_W+3:0] p;
        p = unit * n;
        return p[CNT_W-1:0];
    endfunction : step_clks

    // apb decode: zero wait states, read data caught in the setup cycle
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign apb_rsp.pready = 1'b1;
    assign mapped = (apb_req.paddr == OFS_SCALE) || (apb_req.paddr == OFS_TIMING) ||
                    (apb_req.paddr == OFS_DRVCFG) || (apb_req.paddr == OFS_STATUS);

    // read mux; unused bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (apb_req.paddr)
            OFS_SCALE: begin
                rd_word[HOLD_LSB +: 5] = hold_current_scale;
                rd_word[RUN_LSB +: 5] = run_current_scale;
                rd_word[HOLD_IV_LSB +: 4] = hold_ramp_interval;
                rd_word[RUN_IV_LSB +: 4] = run_ramp_interval;
            end
            OFS_TIMING: rd_word[WAIT_LSB +: 8] = standstill_wait_time;
            OFS_DRVCFG: rd_word[FS_LSB +: 2] = full_scale_current;
            OFS_STATUS: begin
                rd_word[ST_STST_BIT] = standstill_flag;
                rd_word[ST_DOWN_BIT] = (state == ST_WAIT) || (state == ST_DOWN);
                rd_word[ST_UP_BIT] = (state == ST_UP);
                rd_word[ST_CUR_LSB +: 5] = cur_scale;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // response flops; the status register ignores writes without error
    always_ff @(posedge clk) begin
        if (rst) begin
            apb_rsp.prdata <= 32'h0000_0000;
            apb_rsp.pslverr <= 1'b0;
        end else if (setup) begin
            apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
            apb_rsp.pslverr <= !mapped;
        end
    end

    // scale register
    always_ff @(posedge clk) begin
        logic [31:0] w;
        w = 32'h0000_0000;
        if (rst) begin
            hold_current_scale <= RST_SCALE[HOLD_LSB +: 5];
            run_current_scale <= RST_SCALE[RUN_LSB +: 5];
            hold_ramp_interval <= RST_SCALE[HOLD_IV_LSB +: 4];
            run_ramp_interval <= RST_SCALE[RUN_IV_LSB +: 4];
        end else if (wr_en && apb_req.paddr == OFS_SCALE) begin
            w[HOLD_LSB +: 5] = hold_current_scale;
            w[RUN_LSB +: 5] = run_current_scale;
            w[HOLD_IV_LSB +: 4] = hold_ramp_interval;
            w[RUN_IV_LSB +: 4] = run_ramp_interval;
            w = merge(w, apb_req.pwdata, apb_req.pstrb);
            hold_current_scale <= w[HOLD_LSB +: 5];
            run_current_scale <= w[RUN_LSB +: 5];
            hold_ramp_interval <= w[HOLD_IV_LSB +: 4];
            run_ramp_interval <= w[RUN_IV_LSB +: 4];
        end
    end

    // timing register
    always_ff @(posedge clk) begin
        if (rst) begin
            standstill_wait_time <= RST_TIMING[WAIT_LSB +: 8];
        end else if (wr_en && apb_req.paddr == OFS_TIMING && apb_req.pstrb[0]) begin
            standstill_wait_time <= apb_req.pwdata[WAIT_LSB +: 8];
        end
    end

    // driver configuration: range code goes straight to the bridge
    always_ff @(posedge clk) begin
        if (rst) begin
            full_scale_current <= RST_FS; // RL8
        end else if (wr_en && apb_req.paddr == OFS_DRVCFG && apb_req.pstrb[0]) begin
            full_scale_current <= apb_req.pwdata[FS_LSB +: 2]; // RL7
        end
    end

    // standstill detection: saturating count of clocks since the last step
    always_ff @(posedge clk) begin
        if (rst || step_pulse) begin
            idle_cnt <= 21'h000000;
        end else if (idle_cnt != STANDSTILL_CNT) begin
            idle_cnt <= idle_cnt + 21'h000001;
        end
    end
    assign standstill_flag = (idle_cnt == STANDSTILL_CNT); // RL9

    // adaptive reduction may only lower the current below the run setting
    assign run_target = (adapt_en && adapt_scale < run_current_scale) ?
                        adapt_scale : run_current_scale; // RL3

    // ramp sequencing; timer counts down the clocks left in this step
    always_comb begin
        next_state = state;
        next_scale = cur_scale;
        next_timer = (timer != '0) ? timer - ONE : timer;
        case (state)
            ST_RUN: begin
                next_scale = run_target; // RL1
                if (standstill_flag) begin
                    next_state = ST_WAIT;
                    next_timer = (standstill_wait_time < 8'h02) ?
                        CNT_W'(standstill_wait_time) :
                        CNT_W'(WAIT_UNIT * standstill_wait_time);
                end
            end
            ST_WAIT: begin
                if (!standstill_flag) begin
                    next_state = ST_RUN;
                end else if (timer <= ONE) begin
                    next_timer = step_clks(hold_ramp_interval, HOLD_UNIT);
                    if (hold_ramp_interval == 4'h0 || cur_scale <= hold_current_scale) begin
                        next_scale = hold_current_scale; // RL4
                        next_state = ST_HOLD;
                    end else begin
                        next_state = ST_DOWN;
                    end
                end
            end
            ST_DOWN: begin
                if (!standstill_flag) begin
                    next_state = ST_UP; // RL10
                    next_timer = step_clks(run_ramp_interval, RUN_UNIT);
                end else if (cur_scale <= hold_current_scale) begin
                    next_scale = hold_current_scale;
                    next_state = ST_HOLD;
                end else if (timer <= ONE) begin
                    next_scale = cur_scale - 5'h01; // RL5
                    next_timer = step_clks(hold_ramp_interval, HOLD_UNIT); // RL4
                    if (cur_scale - 5'h01 <= hold_current_scale) begin
                        next_state = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                next_scale = hold_current_scale; // RL2
                if (!standstill_flag) begin
                    next_state = ST_UP;
                    next_timer = step_clks(run_ramp_interval, RUN_UNIT);
                end
            end
            ST_UP: begin
                // same wait as from run, so a stop mid power-up waits the full time
                if (standstill_flag) begin
                    next_state = ST_WAIT;
                    next_timer = (standstill_wait_time < 8'h02) ?
                        CNT_W'(standstill_wait_time) :
                        CNT_W'(WAIT_UNIT * standstill_wait_time); // RL4
                end else if (run_ramp_interval == 4'h0 || cur_scale >= run_target) begin
                    next_scale = run_target; // RL6
                    next_state = ST_RUN;
                end else if (timer <= ONE) begin
                    next_scale = cur_scale + 5'h01; // RL6
                    next_timer = step_clks(run_ramp_interval, RUN_UNIT);
                    if (cur_scale + 5'h01 >= run_target) begin
                        next_state = ST_RUN;
                    end
                end
            end
            default: begin
                next_state = ST_RUN;
                next_scale = run_target;
            end
        endcase
    end

    // ramp state flops
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_RUN;
            cur_scale <= 5'h00;
            timer <= '0;
        end else begin
            state <= next_state;
            cur_scale <= next_scale;
            timer <= next_timer;
        end
    end
    assign applied_scale = cur_scale;

    // coil targets registered; one cycle behind the sine inputs
    always_ff @(posedge clk) begin
        if (rst) begin
            coil_target_a <= '0;
            coil_target_b <= '0;
        end else begin
            coil_target_a <= scale_coil(sine_a, cur_scale); // RL1 RL2
            coil_target_b <= scale_coil(sine_b, cur_scale);
        end
    end
endmodule : motor_current_scaling_ramp

`default_nettype wire

// ===== rtl/motor_current_pkg.sv
/*
 package of the motor current scaling block: register map, field layout,
 reset values, timing counts, ramp states and the bus carrier structs.
 assumes an apb master with 32-bit data and one clock shared with it.
*/
// Contract
// [RL1] running: coil value times (run_current_scale+1)/32.
// [RL2] standstill: hold_current_scale applied the same way.
// [RL3] run_current_scale caps what load-adaptive reduction may command.
// [RL4] after standstill_wait_time, ramp down; hold_ramp_interval 0 instant, else n*2^18 clocks.
// [RL5] power-down ramp steps one unit per interval from run to hold.
// [RL6] motion start ramps up; run_ramp_interval 0 instant, else n*512 clocks.
// [RL7] driver_config bits 1..0 select full-scale range: 11, 10 3A; 01 2A.
// [RL8] full-scale field resets to 00, the 1A range.
// [RL9] standstill_flag set after 2^20 clocks without a step pulse.
// [RL10] motion during power-down abandons it, ramps up from present scale.
package motor_current_pkg;
    localparam int ADDR_W = 12;
    localparam int SCALE_W = 5;
    localparam int CNT_W = 28;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_SCALE  = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_TIMING = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_DRVCFG = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;

    // field positions
    localparam int HOLD_LSB = 0;
    localparam int RUN_LSB = 8;
    localparam int HOLD_IV_LSB = 16;
    localparam int RUN_IV_LSB = 24;
    localparam int WAIT_LSB = 0;
    localparam int FS_LSB = 0;
    localparam int ST_STST_BIT = 0;
    localparam int ST_DOWN_BIT = 1;
    localparam int ST_UP_BIT = 2;
    localparam int ST_CUR_LSB = 8;

    // reset values
    localparam logic [31:0] RST_SCALE = 32'h0000_1f10;
    localparam logic [31:0] RST_TIMING = 32'h0000_0000;
    localparam logic [1:0] RST_FS = 2'h0;

    // full-scale range codes
    localparam logic [1:0] FS_1A = 2'h0;
    localparam logic [1:0] FS_2A = 2'h1;
    localparam logic [1:0] FS_3A_STD = 2'h2;
    localparam logic [1:0] FS_3A_EXT = 2'h3;

    // timing counts in clocks
    localparam int STANDSTILL_CLKS = 1048576;
    localparam int WAIT_UNIT_CLKS = 262144;
    localparam int HOLD_UNIT_CLKS = 262144;
    localparam int RUN_UNIT_CLKS = 512;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_WAIT = 3'b001,
        ST_DOWN = 3'b011,
        ST_HOLD = 3'b010,
        ST_UP   = 3'b110
    } ramp_state_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;
endpackage : motor_current_pkg

// ===== verification/motor_current_checker.sv
/* assertions on the ports of the current scaling block, bound into it.
   assumes register writes carry all four byte strobes. */
`timescale 1ns/10ps
`default_nettype none
module motor_current_checker #(
    parameter int          SINE_W         = 9,
    parameter logic [20:0] STANDSTILL_CNT = 21'd64
) (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire motor_current_pkg::apb_req_t apb_req,
    input wire logic                        step_pulse,
    input wire logic signed [SINE_W-1:0]    sine_a,
    input wire logic signed [SINE_W-1:0]    coil_target_a,
    input wire logic [4:0]                  applied_scale,
    input wire logic [1:0]                  full_scale_current,
    input wire logic                        standstill_flag
);
    import motor_current_pkg::*;
    logic        wr;
    logic [4:0]  run_sh;
    logic [4:0]  hold_sh;
    logic [1:0]  fs_sh;
    logic [21:0] idle;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // shadows move at the write edge, as the design's own registers do
    always_ff @(posedge clk) begin
        if (rst) begin
            run_sh  <= RST_SCALE[12:8];
            hold_sh <= RST_SCALE[4:0];
            fs_sh   <= RST_FS;
        end else if (wr && apb_req.paddr == OFS_SCALE) begin
            run_sh  <= apb_req.pwdata[12:8];
            hold_sh <= apb_req.pwdata[4:0];
        end else if (wr && apb_req.paddr == OFS_DRVCFG) begin
            fs_sh <= apb_req.pwdata[1:0];
        end
    end
    // clocks since the last step, saturating so it cannot wrap
    always_ff @(posedge clk) begin
        if (rst || step_pulse) idle <= '0;
        else if (idle != '1) idle <= idle + 22'd1;
    end
    function automatic logic signed [SINE_W-1:0] scl(logic signed [SINE_W-1:0] v, logic [4:0] s);
        logic signed [SINE_W+6:0] p;
        p = v * $signed({2'b00, s} + 7'd1);
        return SINE_W'(p >>> 5);
    endfunction : scl
    sequence s_still;
        standstill_flag ##1 standstill_flag;
    endsequence
    a_coil_scale: assert property (!$past(rst) |->
        coil_target_a == scl($past(sine_a), $past(applied_scale))) else $error("coil target off");
    a_flag_set: assert property (idle > 22'(STANDSTILL_CNT) + 22'd1 |-> standstill_flag)
        else $error("standstill late");
    a_flag_quiet: assert property (idle + 22'd2 < 22'(STANDSTILL_CNT) |-> !standstill_flag)
        else $error("standstill early");
    a_step_clear: assert property (step_pulse |=> !standstill_flag)
        else $error("step kept standstill");
    a_down_mono: assert property (s_still |-> applied_scale <= $past(applied_scale))
        else $error("scale rose at standstill");
    a_down_unit: assert property (s_still ##0 applied_scale != hold_sh |->
        6'(applied_scale) + 6'd1 >= 6'($past(applied_scale))) else $error("drop above one");
    a_range_reg: assert property (full_scale_current == fs_sh)
        else $error("range field wrong");
    a_scale_cap: assert property (!standstill_flag |->
        applied_scale <= run_sh || applied_scale <= $past(run_sh)) else $error("above run");
endmodule : motor_current_checker
bind motor_current_scaling_ramp motor_current_checker #(
    .SINE_W(SINE_W), .STANDSTILL_CNT(STANDSTILL_CNT)
) motor_current_checker_i (
    .clk(clk), .rst(rst), .apb_req(apb_req), .step_pulse(step_pulse), .sine_a(sine_a),
    .coil_target_a(coil_target_a), .applied_scale(applied_scale),
    .full_scale_current(full_scale_current), .standstill_flag(standstill_flag)
);
`default_nettype wire

// ===== verification/coil_bridge_model.sv
/* far side: bridge current regulation turning coil targets into current.
   assumes signed targets with full scale at 256. */
`timescale 1ns/10ps
`default_nettype none
module coil_bridge_model (
    input  wire logic              clk,
    input  wire logic signed [8:0] drive_a,
    input  wire logic [1:0]        range_sel,
    output var int                 range_ma,
    output var int                 coil_ma_a
);
    // both top codes give 3 a; they differ only in operating range
    always_comb begin
        case (range_sel)
            2'h3, 2'h2: range_ma = 3000;
            2'h1:       range_ma = 2000;
            default:    range_ma = 1000;
        endcase
    end
    // current settles one clock after the target, chopper ripple ignored
    always_ff @(posedge clk) coil_ma_a <= drive_a * range_ma / 256;
endmodule : coil_bridge_model
`default_nettype wire

// ===== verification/motor_current_scaling_ramp_tb_top.sv
/* testbench top: register, scaling and ramp scenarios with seeded values.
   assumes the checker and bridge model are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module motor_current_scaling_ramp_tb_top;
    import motor_current_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    apb_req_t          req = '0;
    apb_rsp_t          rsp;
    logic              step_pulse = 1'b0;
    logic              stepping = 1'b0;
    logic [4:0]        ph = '0;
    logic              adapt_en = 1'b0;
    logic [4:0]        adapt_scale = '0;
    logic signed [8:0] sine_a = '0;
    logic signed [8:0] sine_b = '0;
    logic signed [8:0] coil_a;
    logic signed [8:0] coil_b;
    logic [4:0]        applied;
    logic [1:0]        fs;
    logic              flag;
    int                range_ma;
    int                bad_count = 0;
    int                check_count = 0;
    always #4 clk = ~clk;
    // a step every 32 clocks keeps the 64-clock idle limit from expiring
    always @(posedge clk) begin
        ph <= ph + 5'd1;
        step_pulse <= stepping && ph == 5'd0;
        sine_a <= 9'($urandom);
        sine_b <= 9'($urandom);
    end
    motor_current_scaling_ramp #(
        .SINE_W(9), .STANDSTILL_CNT(21'd64), .WAIT_UNIT(28'd8), .HOLD_UNIT(28'd8)
    ) motor_current_scaling_ramp_i (
        .clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .step_pulse(step_pulse),
        .adapt_en(adapt_en), .adapt_scale(adapt_scale), .sine_a(sine_a), .sine_b(sine_b),
        .coil_target_a(coil_a), .coil_target_b(coil_b), .applied_scale(applied),
        .full_scale_current(fs), .standstill_flag(flag)
    );
    coil_bridge_model coil_bridge_model_i (
        .clk(clk), .drive_a(coil_a), .range_sel(fs), .range_ma(range_ma), .coil_ma_a()
    );
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic hang();
        $display("MISMATCH wait expected 1 seen 0");
        bad_count++;
        end_sim();
    endtask : hang
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int i;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hf};
        @(posedge clk);
        req.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        if (i == 16) hang();
    endtask : apb
    function automatic logic signed [8:0] exp_coil(input logic signed [8:0] v, input int s);
        return 9'((v * (s + 1)) >>> 5);
    endfunction : exp_coil
    task automatic coil(input int s);
        logic signed [8:0] v;
        logic signed [8:0] vb;
        repeat (4) begin
            tick(1);
            v = sine_a;
            vb = sine_b;
            tick(1);
            chk("coil_target_a", exp_coil(v, s), coil_a);
            chk("coil_target_b", exp_coil(vb, s), coil_b);
        end
    endtask : coil
    task automatic wait_flag(input logic v, output int i);
        for (i = 0; i < 300 && flag !== v; i++) tick(1);
        if (i == 300) hang();
    endtask : wait_flag
    // counts scale changes until the target; interval ramps must move by one
    task automatic track(input int tgt, input int iv, input int maxn, output int n, output int c);
        logic [4:0] prev;
        prev = applied;
        n = 0;
        for (c = 0; c < 20000 && applied !== 5'(tgt) && n < maxn; c++) begin
            tick(1);
            if (applied !== prev) begin
                n++;
                if (iv != 0) chk("step", 1, applied > prev ? applied - prev : prev - applied);
                prev = applied;
            end
        end
        if (c == 20000) hang();
    endtask : track
    initial begin : main
        logic [31:0] q;
        logic        e;
        int          r, h, hiv, riv, n, c, cur, i;
        void'($urandom(80196));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        stepping <= 1'b1;
        apb(1'b0, OFS_SCALE, '0, q, e);
        chk("scale", RST_SCALE, q);
        apb(1'b0, 12'h010, '0, q, e);
        chk("slverr", 1, e);
        apb(1'b0, OFS_DRVCFG, '0, q, e);
        chk("range", RST_FS, q);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, OFS_DRVCFG, i, q, e);
            tick(1);
            chk("range", i, fs);
            chk("range_ma", i == 0 ? 1000 : i == 1 ? 2000 : 3000, range_ma);
        end
        // pass 0 instant both ways, pass 1 full slow ramps, pass 2 resumes mid-ramp
        for (int it = 0; it < 3; it++) begin
            r = 16 + $urandom % 16;
            h = $urandom % 8;
            hiv = it * it;
            riv = it % 2;
            apb(1'b1, OFS_SCALE, riv << 24 | hiv << 16 | r << 8 | h, q, e);
            // wait time 0, 1 clock and 2 units across the passes
            apb(1'b1, OFS_TIMING, it, q, e);
            apb(1'b0, OFS_TIMING, '0, q, e);
            chk("wait_time", it, q);
            tick(4);
            chk("run", r, applied);
            coil(r);
            @(posedge clk);
            adapt_scale <= 5'(r - 3);
            adapt_en <= 1'b1;
            tick(3);
            chk("adapt", r - 3, applied);
            i = 0;
            do @(posedge clk); while (step_pulse !== 1'b1 && ++i < 40);
            adapt_en <= 1'b0;
            stepping <= 1'b0;
            wait_flag(1'b1, i);
            chk("idle", 1, i >= 60);
            track(h, hiv, it == 2 ? 3 : 99, n, c);
            if (it < 2) begin
                chk("hold", h, applied);
                chk("downs", hiv == 0 ? 1 : r - h, n);
                coil(h);
                apb(1'b0, OFS_STATUS, '0, q, e);
                chk("status", (h << 8) | 1, q);
            end
            @(posedge clk);
            stepping <= 1'b1;
            wait_flag(1'b0, i);
            cur = applied;
            track(r, riv, 99, n, c);
            chk("up", r, applied);
            chk("ups", riv == 0 ? 1 : r - cur, n);
            chk("up_time", 1, c >= (n - 1) * 512 * riv);
        end
        end_sim();
    end
endmodule : motor_current_scaling_ramp_tb_top
`default_nettype wire
